// ===== rtl/branch_resolve_pkg.sv
package branch_resolve_pkg;

   // datapath widths
   localparam int XLEN = 64;                    // register and address width
   localparam int IW   = 32;                    // instruction word width

   // major opcodes, bits 31:26
   localparam logic [5:0] OP_SPECIAL       = 6'h00;
   localparam logic [5:0] OP_REGISTER_IMMEDIATE_CLASS        = 6'h01;   // register_immediate_class
   localparam logic [5:0] OP_EQUAL         = 6'h04;
   localparam logic [5:0] OP_UNEQUAL       = 6'h05;
   localparam logic [5:0] OP_NONPOSITIVE   = 6'h06;
   localparam logic [5:0] OP_POSITIVE      = 6'h07;
   localparam logic [5:0] OP_SYSCO         = 6'h10;   // system_coprocessor_class
   localparam logic [5:0] OP_EQUAL_LK      = 6'h14;
   localparam logic [5:0] OP_UNEQUAL_LK    = 6'h15;
   localparam logic [5:0] OP_NONPOS_LK     = 6'h16;
   localparam logic [5:0] OP_POSITIVE_LK   = 6'h17;

   // register-immediate sub-codes, bits 20:16
   localparam logic [4:0] RI_NEG           = 5'h00;
   localparam logic [4:0] RI_NONNEG        = 5'h01;
   localparam logic [4:0] RI_NEG_LK        = 5'h02;
   localparam logic [4:0] RI_NONNEG_LK     = 5'h03;
   localparam logic [4:0] RI_NEG_LINK      = 5'h10;
   localparam logic [4:0] RI_NONNEG_LINK   = 5'h11;
   localparam logic [4:0] RI_NEG_LINK_LK   = 5'h12;
   localparam logic [4:0] RI_NONNEG_LINK_LK = 5'h13;

   // coprocessor branch sub-op (bits 25:21) and condition (bits 20:16)
   localparam logic [4:0] SC_BRANCH        = 5'h08;
   localparam logic [4:0] SC_FALSE         = 5'h00;
   localparam logic [4:0] SC_TRUE          = 5'h01;
   localparam logic [4:0] SC_FALSE_LK      = 5'h02;
   localparam logic [4:0] SC_TRUE_LK       = 5'h03;

   // special function codes, bits 5:0
   localparam logic [5:0] FN_SYSCALL       = 6'h0c;
   localparam logic [5:0] FN_BREAK         = 6'h0d;
   localparam logic [5:0] FN_SYNC          = 6'h0f;

   // addressing constants
   localparam logic [4:0]      LINK_REG    = 5'h1f;   // general register 31
   localparam logic [XLEN-1:0] SLOT_STEP   = 64'h0000_0000_0000_0004;
   localparam logic [XLEN-1:0] LINK_STEP   = 64'h0000_0000_0000_0008;
   localparam logic [XLEN-1:0] TARGET_RST  = 64'h0000_0000_0000_0000;
   localparam int              OFFSET_SHIFT = 2;

   // branch condition kinds
   typedef enum logic [2:0] {
      COND_EQ, COND_NE, COND_LEZ, COND_GTZ,
      COND_LTZ, COND_GEZ, COND_SC_TRUE, COND_SC_FALSE
   } cond_e;

   // decoded view of one instruction
   typedef struct packed {
      logic        is_branch;   // any conditional branch
      logic        likely;      // slot dropped when not taken
      logic        link;        // writes return address to r31
      cond_e       cond;        // condition to evaluate
      logic        is_sync;
      logic        is_syscall;
      logic        is_break;
      logic [15:0] offset;      // raw branch offset
   } dec_s;

   // resolved outcome of a branch in the register fetch stage
   typedef struct packed {
      logic            taken;
      logic [XLEN-1:0] target;
      logic [XLEN-1:0] link_addr;
   } res_s;

endpackage

// ===== rtl/branch_decoder.sv
`timescale 1ns/1ps
// pure decode of the instruction word into branch and special flags
module branch_decoder
   import branch_resolve_pkg::*;
(
   input  wire logic [IW-1:0] insn_in,
   output dec_s               dec_out
);

   logic [5:0] op;        // major opcode
   logic [4:0] rs_f;      // rs field
   logic [4:0] rt_f;      // rt field
   logic [5:0] fn;        // function field

   assign op   = insn_in[31:26];
   assign rs_f = insn_in[25:21];
   assign rt_f = insn_in[20:16];
   assign fn   = insn_in[5:0];

   // opcode table; unknown codes decode to nothing
   always_comb begin
      dec_out        = '0;
      dec_out.cond   = COND_EQ;
      dec_out.offset = insn_in[15:0];
      unique case (op)
         OP_EQUAL, OP_EQUAL_LK: begin
            dec_out.is_branch = 1'b1;
            dec_out.likely    = (op == OP_EQUAL_LK);
            dec_out.cond      = COND_EQ;
         end
         OP_UNEQUAL, OP_UNEQUAL_LK: begin
            dec_out.is_branch = 1'b1;
            dec_out.likely    = (op == OP_UNEQUAL_LK);
            dec_out.cond      = COND_NE;
         end
         OP_NONPOSITIVE, OP_NONPOS_LK: begin
            dec_out.is_branch = 1'b1;
            dec_out.likely    = (op == OP_NONPOS_LK);
            dec_out.cond      = COND_LEZ;
         end
         OP_POSITIVE, OP_POSITIVE_LK: begin
            dec_out.is_branch = 1'b1;
            dec_out.likely    = (op == OP_POSITIVE_LK);
            dec_out.cond      = COND_GTZ;
         end
         OP_REGISTER_IMMEDIATE_CLASS: begin
            // bit 0 picks nonnegative, bit 1 likely, bit 4 link
            if ((rt_f & 5'h0c) == 5'h00) begin
               dec_out.is_branch = 1'b1;
               dec_out.likely    = rt_f[1];
               dec_out.link      = rt_f[4];
               dec_out.cond      = rt_f[0] ? COND_GEZ : COND_LTZ;
            end
         end
         OP_SYSCO: begin
            if (rs_f == SC_BRANCH && rt_f[4:2] == 3'h0) begin
               dec_out.is_branch = 1'b1;
               dec_out.likely    = rt_f[1];
               dec_out.cond      = rt_f[0] ? COND_SC_TRUE : COND_SC_FALSE;
            end
         end
         OP_SPECIAL: begin
            dec_out.is_sync    = (fn == FN_SYNC);
            dec_out.is_syscall = (fn == FN_SYSCALL);
            dec_out.is_break   = (fn == FN_BREAK);
         end
         default: begin
            // not a block instruction
         end
      endcase
   end

endmodule

// ===== rtl/branch_condition.sv
`timescale 1ns/1ps
// condition test and target arithmetic for the register fetch stage
module branch_condition
   import branch_resolve_pkg::*;
(
   input  dec_s                 dec_in,
   input  wire logic [XLEN-1:0] pc_in,
   input  wire logic [XLEN-1:0] rs_in,
   input  wire logic [XLEN-1:0] rt_in,
   input  wire logic            sysco_cond_in,
   output res_s                 res_out
);

   logic signed [XLEN-1:0] rs_s;       // source viewed as signed
   logic [31:0]            off32;      // offset scaled, 32-bit extended
   logic [XLEN-1:0]        slot_pc;    // delay-slot address

   assign rs_s    = rs_in;
   assign slot_pc = pc_in + SLOT_STEP;
   assign off32   = {{14{dec_in.offset[15]}}, dec_in.offset, 2'b00};

   // full-width extension; coprocessor branches share it since the
   // 32-bit form widens to the same value
   always_comb begin
      res_out.target    = slot_pc + {{32{off32[31]}}, off32};
      res_out.link_addr = pc_in + LINK_STEP;
      unique case (dec_in.cond)
         COND_EQ:       res_out.taken = (rs_in == rt_in);
         COND_NE:       res_out.taken = (rs_in != rt_in);
         COND_LEZ:      res_out.taken = (rs_s <= 0);
         COND_GTZ:      res_out.taken = (rs_s > 0);
         COND_LTZ:      res_out.taken = (rs_s < 0);
         COND_GEZ:      res_out.taken = (rs_s >= 0);
         COND_SC_TRUE:  res_out.taken = sysco_cond_in;
         COND_SC_FALSE: res_out.taken = !sysco_cond_in;
      endcase
   end

endmodule

// ===== rtl/branch_resolve_unit.sv
`timescale 1ns/1ps
// How it works
// - target is slot address plus scaled offset
// - branch redirects after exactly one slot instruction
// - likely branch not taken nullifies slot
// - ordinary branches always execute the slot
// - target fetch starts while branch in execute
// - compare in fetch stage, registered into execute
// - jumps get the same one slot delay
// - equal and unequal compare two registers
// - zero compares per variant on one register
// - link variants write next-after-slot into r31
// - likely link variants link and drop slot
// - coprocessor condition selects true or false branch
// - coprocessor offset scaled, extended, added to slot
// - coprocessor branches have likely forms too
// - sync holds loads stores until pipeline drains
// - system call raises its exception
// - breakpoint raises its exception
module branch_resolve_unit
   import branch_resolve_pkg::*;
(
   input  wire logic            clock_in,
   input  wire logic            rst_n_in,
   input  wire logic            rf_valid_in,
   input  wire logic [IW-1:0]   rf_insn_in,
   input  wire logic [XLEN-1:0] rf_pc_in,
   input  wire logic [XLEN-1:0] rs_value_in,
   input  wire logic [XLEN-1:0] rt_value_in,
   input  wire logic            sysco_cond_in,
   input  wire logic            jump_valid_in,
   input  wire logic [XLEN-1:0] jump_target_in,
   input  wire logic            ls_busy_in,
   output logic                 redirect_valid_out,
   output logic [XLEN-1:0]      redirect_target_out,
   output logic                 slot_nullify_out,
   output logic                 link_we_out,
   output logic [4:0]           link_reg_out,
   output logic [XLEN-1:0]      link_data_out,
   output logic                 syscall_exc_out,
   output logic                 break_exc_out,
   output logic                 hold_ls_out
);

   // the checks below all share this clock and reset
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   ////////////////////////////////////////////////////////////////////
   // decode and resolve in the register fetch stage
   // nothing here is registered; only the answers
   // below leave the block, one edge later

   dec_s  dec;            // decoded fetch-stage instruction
   res_s  res;            // condition and target for it
   logic  in_slot_q;      // fetch-stage instruction is a delay slot
   logic  live;           // fetch-stage instruction may act
   logic  br_go;          // branch accepted this cycle
   logic  jmp_go;         // jump accepted this cycle

   // encodings come from the decoder tables
   // unknown words decode to no action at all
   branch_decoder u_decoder (
      .insn_in (rf_insn_in),
      .dec_out (dec)
   );

   // comparison and adder run combinationally in the fetch stage
   // the 64-bit compare is the long path here, so
   // a late operand bypass costs timing
   branch_condition u_condition (
      .dec_in        (dec),
      .pc_in         (rf_pc_in),
      .rs_in         (rs_value_in),
      .rt_in         (rt_value_in),
      .sysco_cond_in (sysco_cond_in),
      .res_out       (res)
   );

   // a nullified slot has no effect at all
   assign live   = rf_valid_in && !slot_nullify_out;
   // a control transfer sitting in a slot is ignored, so the
   // redirect never lands inside another slot
   assign br_go  = live && dec.is_branch && !in_slot_q;
   assign jmp_go = live && jump_valid_in && !in_slot_q;

   ////////////////////////////////////////////////////////////////////
   // slot tracking
   // a bubble keeps the mark: the slot is the next
   // valid instruction, not the next cycle

   // marks the next valid fetch-stage instruction as a delay slot
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         in_slot_q <= 1'b0;
      end else if (br_go || jmp_go) begin
         in_slot_q <= 1'b1;
      end else if (rf_valid_in) begin
         in_slot_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // redirect to the fetch stage, one stage after the compare
   // limitation: fetch must advance every cycle,
   // or the target lands one slot late; a stall
   // input was left out to keep this small

   // the slot is already fetched, so the target comes next in line
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         redirect_valid_out  <= 1'b0;
         redirect_target_out <= TARGET_RST;
      end else if (br_go) begin
         redirect_valid_out  <= res.taken;
         redirect_target_out <= res.target;
      end else if (jmp_go) begin
         redirect_valid_out  <= 1'b1;
         redirect_target_out <= jump_target_in;
      end else begin
         redirect_valid_out  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // delay-slot nullify
   // the pulse stands while the slot sits in
   // the fetch stage

   // only a failed likely branch drops its slot
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         slot_nullify_out <= 1'b0;
      end else begin
         slot_nullify_out <= br_go && dec.likely && !res.taken;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link register write
   // the return address skips over the slot and
   // holds between writes

   // link happens whether taken or not, likely or not
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         link_we_out   <= 1'b0;
         link_reg_out  <= LINK_REG;
         link_data_out <= TARGET_RST;
      end else begin
         link_we_out   <= br_go && dec.link;
         link_reg_out  <= LINK_REG;
         if (br_go && dec.link) begin
            link_data_out <= res.link_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // software exceptions
   // these still act inside a delay slot, and
   // each lasts exactly one cycle

   // one-cycle requests to the exception logic in execute
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         syscall_exc_out <= 1'b0;
         break_exc_out   <= 1'b0;
      end else begin
         syscall_exc_out <= live && dec.is_syscall;
         break_exc_out   <= live && dec.is_break;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // synchronize barrier
   // one state bit is enough: a second sync
   // only extends the hold

   typedef enum logic {SYNC_IDLE, SYNC_HOLD} sync_e;
   sync_e sync_q;   // barrier state
   sync_e sync_d;   // next barrier state

   // leave only once the memory pipe reports empty; a new sync in
   // that cycle keeps the hold, so the set wins over the release
   always_comb begin
      sync_d = sync_q;
      unique case (sync_q)
         SYNC_IDLE: if (live && dec.is_sync) sync_d = SYNC_HOLD;
         SYNC_HOLD: if (!ls_busy_in && !(live && dec.is_sync)) sync_d = SYNC_IDLE;
      endcase
   end

   // hold output mirrors the next state so it leaves a flop
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sync_q      <= SYNC_IDLE;
         hold_ls_out <= 1'b0;
      end else begin
         sync_q      <= sync_d;
         hold_ls_out <= (sync_d == SYNC_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   // each property but a_redirect_cause looks one edge past the
   // fetch-stage event that it guards; that one looks back one edge

   a_target_form: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      br_go |=> redirect_target_out == $past(rf_pc_in) + SLOT_STEP
         + {{46{$past(rf_insn_in[15])}}, $past(rf_insn_in[15:0]), 2'b00})
      else $error("branch target not slot plus scaled offset");

   a_single_redirect: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && res.taken) |=> redirect_valid_out ##1 !redirect_valid_out)
      else $error("taken branch redirect not exactly one cycle");

   a_likely_nullify: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && dec.likely && !res.taken) |=> slot_nullify_out && !redirect_valid_out)
      else $error("failed likely branch did not nullify slot");

   a_plain_keeps_slot: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && !dec.likely) |=> !slot_nullify_out)
      else $error("ordinary branch nullified its slot");

   a_redirect_cause: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      redirect_valid_out |-> $past(br_go && res.taken) || $past(jmp_go))
      else $error("redirect without a taken transfer");

   a_jump_delay: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (jmp_go && !br_go) |=> redirect_valid_out
         && redirect_target_out == $past(jump_target_in))
      else $error("jump redirect wrong");

   a_equal_compare: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && dec.cond == COND_EQ) |=>
         redirect_valid_out == ($past(rs_value_in) == $past(rt_value_in)))
      else $error("equal branch outcome wrong");

   a_signed_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && dec.cond == COND_LTZ) |=> redirect_valid_out == $past(rs_value_in[63]))
      else $error("negative branch ignores sign bit");

   a_link_value: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && dec.link) |=> link_we_out && link_reg_out == LINK_REG
         && link_data_out == $past(rf_pc_in) + LINK_STEP)
      else $error("link write wrong");

   a_sysco_branch: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (br_go && dec.cond == COND_SC_TRUE) |=> redirect_valid_out == $past(sysco_cond_in))
      else $error("coprocessor true branch outcome wrong");

   a_sync_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      ((live && dec.is_sync) || (hold_ls_out && ls_busy_in)) |=> hold_ls_out)
      else $error("sync released while memory busy");

   a_exc_raise: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      live |=> syscall_exc_out == $past(dec.is_syscall)
         && break_exc_out == $past(dec.is_break))
      else $error("software exception not raised");

   // a branch sitting in a slot never steers fetch
   a_slot_ignored: assert property (
      (rf_valid_in && in_slot_q && dec.is_branch)
         |=> !redirect_valid_out)
      else $error("branch in a delay slot redirected");

   // the hold drops on the first quiet edge
   a_sync_release: assert property (
      (hold_ls_out && !ls_busy_in && !(live && dec.is_sync))
         |=> !hold_ls_out)
      else $error("sync hold outlived the memory pipe");

   // the false form mirrors the true form
   a_sysco_false: assert property (
      (br_go && dec.cond == COND_SC_FALSE)
         |=> redirect_valid_out == !$past(sysco_cond_in))
      else $error("coprocessor false branch outcome wrong");

   // the sign bit alone decides
   a_nonneg_compare: assert property (
      (br_go && dec.cond == COND_GEZ)
         |=> redirect_valid_out == !$past(rs_value_in[63]))
      else $error("nonnegative branch ignores sign bit");

   // a difference in any bit counts
   a_unequal_compare: assert property (
      (br_go && dec.cond == COND_NE)
         |=> redirect_valid_out == ($past(rs_value_in) != $past(rt_value_in)))
      else $error("unequal branch outcome wrong");

   // a bubble or a killed slot raises nothing
   a_exc_quiet: assert property (
      !live |=> !syscall_exc_out && !break_exc_out && !link_we_out)
      else $error("dead instruction raised an event");

endmodule

// ===== testbench/pipe_partner.sv
`timescale 1ns/1ps
// stand-in for the coprocessor condition source and the load/store pipeline
module pipe_partner (
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       cond_set_in,
   input  wire logic       busy_start_in,
   input  wire logic [3:0] busy_len_in,
   output logic            sysco_cond_out,
   output logic            ls_busy_out
);
   logic [3:0] left_q;   // outstanding load/store operations

   ////////////////////////////////////////////////////////////////////////////////
   // the coprocessor owns the condition line and drives it at all times
   assign sysco_cond_out = cond_set_in;

   // outstanding accesses drain one per cycle; a new burst restarts the count
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         left_q <= 4'h0;
      end else if (busy_start_in) begin
         left_q <= busy_len_in;
      end else if (left_q != 4'h0) begin
         left_q <= left_q - 4'h1;
      end
   end

   // busy while anything is still in flight
   assign ls_busy_out = (left_q != 4'h0);
endmodule

// ===== testbench/branch_resolve_unit_tb.sv
`timescale 1ns/1ps
// self-checking bench: every test but t_reset issues words and judges the registered answer
module branch_resolve_unit_tb;
   import branch_resolve_pkg::*;

   logic            clk = 1'b0;   // 200 MHz
   logic            rst_n = 1'b0;
   logic            rf_valid = 1'b0;
   logic [31:0]     rf_insn = 32'h0000_0000;
   logic [63:0]     rf_pc = '0;
   logic [63:0]     rs_v = '0;
   logic [63:0]     rt_v = '0;
   logic            jv = 1'b0;
   logic [63:0]     jt = '0;
   logic            cond_set = 1'b0;
   logic            busy_start = 1'b0;
   logic [3:0]      busy_len = 4'h0;
   logic            sysco_cond;
   logic            ls_busy;
   logic            redir, nullify, lwe, sys_exc, brk_exc, hold;
   logic [63:0]     tgt_o, ldata_o;
   logic [4:0]      lreg_o;
   logic [5:0]      obs_f;       // flags seen between edges
   logic [63:0]     obs_tgt, obs_ld;
   logic            obs_busy;
   int              miscompares = 0;
   int              num_checks = 0;

   always #2.5 clk = ~clk;

   branch_resolve_unit i_branch_resolve_unit (
      .clock_in(clk), .rst_n_in(rst_n), .rf_valid_in(rf_valid), .rf_insn_in(rf_insn),
      .rf_pc_in(rf_pc), .rs_value_in(rs_v), .rt_value_in(rt_v), .sysco_cond_in(sysco_cond),
      .jump_valid_in(jv), .jump_target_in(jt), .ls_busy_in(ls_busy),
      .redirect_valid_out(redir), .redirect_target_out(tgt_o), .slot_nullify_out(nullify),
      .link_we_out(lwe), .link_reg_out(lreg_o), .link_data_out(ldata_o),
      .syscall_exc_out(sys_exc), .break_exc_out(brk_exc), .hold_ls_out(hold));

   pipe_partner i_pipe_partner (
      .clock_in(clk), .rst_n_in(rst_n), .cond_set_in(cond_set), .busy_start_in(busy_start),
      .busy_len_in(busy_len), .sysco_cond_out(sysco_cond), .ls_busy_out(ls_busy));

   ////////////////////////////////////////////////////////////////////////////////
   // snapshot mid-cycle so checks never race the edge that updates outputs
   always @(negedge clk) begin
      obs_f    = {redir, nullify, lwe, sys_exc, brk_exc, hold};
      obs_tgt  = tgt_o;
      obs_ld   = ldata_o;
      obs_busy = ls_busy;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // slot address plus scaled, sign-extended offset
   function automatic logic [63:0] tgt(input logic [63:0] pc, input logic [15:0] off);
      return pc + SLOT_STEP + {{46{off[15]}}, off, 2'b00};
   endfunction

   // present one word for one edge; entered and left at a rising edge
   task automatic issue(input logic [31:0] w, input logic [63:0] pc, rs, rt);
      rf_valid <= 1'b1;
      rf_insn  <= w;
      rf_pc    <= pc;
      rs_v     <= rs;
      rt_v     <= rt;
      @(posedge clk);
   endtask

   // bubble cycle; also drops one-shot stimulus
   task automatic idle();
      rf_valid   <= 1'b0;
      jv         <= 1'b0;
      busy_start <= 1'b0;
      @(posedge clk);
   endtask

   // branch followed by a plain slot word, then judge the branch's answer
   task automatic branch(input logic [31:0] w, input logic [63:0] pc, rs, rt,
                         input logic tk, lk, ln);
      issue(w, pc, rs, rt);
      issue(32'h0000_0000, pc + SLOT_STEP, rs, rt);
      check(64'(obs_f), 64'({tk, lk & !tk, ln, 3'b000}));
      if (tk) check(obs_tgt, tgt(pc, w[15:0]));
      if (ln) check(obs_ld, pc + LINK_STEP);
      if (ln) check(64'(lreg_o), 64'(LINK_REG));
      idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      idle();
      check(64'(obs_f), 64'h0);
      check(obs_tgt, TARGET_RST);
      check(64'(lreg_o), 64'(LINK_REG));
      $display("done reset values");
   endtask

   // equal/unequal, plain and likely; operands differ only in the top bit
   task automatic t_two_reg();
      logic [5:0]  ops [4];
      logic [63:0] a;
      ops = '{OP_EQUAL, OP_UNEQUAL, OP_EQUAL_LK, OP_UNEQUAL_LK};
      a = 64'h8000_0000_0000_1234;
      for (int j = 0; j < 4; j++) begin
         for (int e = 0; e < 2; e++) begin
            branch({ops[j], 5'h01, 5'h02, 16'h8000}, 64'h0000_0000_0001_0000, a,
                   e[0] ? a : a ^ 64'h8000_0000_0000_0000, j[0] ^ e[0], j[1], 1'b0);
         end
      end
      $display("done two-register branches");
   endtask

   // every zero-compare form against sign, zero and upper-half values
   task automatic t_zero();
      logic [5:0]  zop [4];
      logic [4:0]  zsub [8];
      logic [63:0] vals [4];
      logic [31:0] w;
      logic        ng, zr, tk, lk, ln;
      int          k;
      zop  = '{OP_NONPOSITIVE, OP_POSITIVE, OP_NONPOS_LK, OP_POSITIVE_LK};
      zsub = '{RI_NEG, RI_NONNEG, RI_NEG_LK, RI_NONNEG_LK,
               RI_NEG_LINK, RI_NONNEG_LINK, RI_NEG_LINK_LK, RI_NONNEG_LINK_LK};
      vals = '{64'h8000_0000_0000_0000, 64'h0, 64'h0000_0001_0000_0000, 64'hffff_ffff_ffff_ffff};
      for (int i = 0; i < 12; i++) begin
         for (int v = 0; v < 4; v++) begin
            k  = (i < 4) ? i % 2 : 2 + i % 2;
            lk = (i < 4) ? i[1] : ((i - 4) >> 1) % 2;
            ln = (i >= 8);
            w  = (i < 4) ? {zop[i], 5'h03, 5'h00, 16'h0010} : {OP_REGISTER_IMMEDIATE_CLASS, 5'h03, zsub[i-4], 16'h0010};
            ng = vals[v][63];
            zr = (vals[v] == 64'h0);
            case (k)
               0: tk = ng | zr;
               1: tk = !ng & !zr;
               2: tk = ng;
               default: tk = !ng;
            endcase
            branch(w, 64'hffff_ffff_8000_0100, vals[v], 64'h0, tk, lk, ln);
         end
      end
      $display("done zero-compare branches");
   endtask

   // coprocessor condition branches, plain and likely, largest forward offset
   task automatic t_sysco();
      logic [4:0] sc [4];
      sc = '{SC_FALSE, SC_TRUE, SC_FALSE_LK, SC_TRUE_LK};
      for (int j = 0; j < 4; j++) begin
         for (int c = 0; c < 2; c++) begin
            cond_set <= c[0];
            branch({OP_SYSCO, SC_BRANCH, sc[j], 16'h7fff}, 64'h0000_0000_0000_2000,
                   64'h0, 64'h0, j[0] == c[0], j[1], 1'b0);
         end
      end
      $display("done coprocessor branches");
   endtask

   // slot handling: killed slot, executed slot, branch in slot, jump
   task automatic t_slots();
      issue({OP_UNEQUAL_LK, 10'h0, 16'h0004}, 64'h100, 64'h5, 64'h5);
      issue({26'h0, FN_SYSCALL}, 64'h104, 64'h0, 64'h0);
      check(64'(obs_f), 64'h10);
      idle();
      check(64'(obs_f), 64'h0);
      issue({OP_UNEQUAL, 10'h0, 16'h0004}, 64'h200, 64'h5, 64'h5);
      issue({26'h0, FN_SYSCALL}, 64'h204, 64'h0, 64'h0);
      check(64'(obs_f), 64'h0);
      idle();
      check(64'(obs_f), 64'h04);
      issue({OP_EQUAL, 10'h0, 16'h0004}, 64'h300, 64'h1, 64'h1);
      issue({OP_EQUAL, 10'h0, 16'h0040}, 64'h304, 64'h1, 64'h1);
      check(64'(obs_f), 64'h20);
      check(obs_tgt, 64'h0000_0000_0000_0314);
      idle();
      check(64'(obs_f), 64'h0);
      jv <= 1'b1;
      jt <= 64'h0000_0000_0040_0000;
      issue(32'h0000_0000, 64'h400, 64'h0, 64'h0);
      idle();
      check(64'(obs_f), 64'h20);
      check(obs_tgt, 64'h0000_0000_0040_0000);
      $display("done delay slots");
   endtask

   // back-to-back system call and breakpoint, each a single pulse
   task automatic t_exc();
      issue({26'h0, FN_SYSCALL}, 64'h500, 64'h0, 64'h0);
      issue({26'h0, FN_BREAK}, 64'h504, 64'h0, 64'h0);
      check(64'(obs_f), 64'h04);
      idle();
      check(64'(obs_f), 64'h02);
      idle();
      check(64'(obs_f), 64'h0);
      $display("done exceptions");
   endtask

   // barrier holds while earlier accesses drain, drops after the last one
   task automatic t_sync();
      logic exp;
      int   n;
      exp        = 1'b1;
      busy_len   <= 4'h3;
      busy_start <= 1'b1;
      issue({26'h0, FN_SYNC}, 64'h600, 64'h0, 64'h0);
      for (n = 0; n < 20; n++) begin
         idle();
         check(64'(obs_f[0]), 64'(exp));
         if (!exp) break;
         exp = obs_busy;
      end
      if (n == 20) begin
         miscompares++;
         $display("BAD at %0t: barrier never released", $time);
      end
      $display("done sync barrier");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_two_reg();
      t_zero();
      t_sysco();
      t_slots();
      t_exc();
      t_sync();
      complete_run();
   end
endmodule
